// [bwr_pkg.sv]
// Constants, field layouts and carrier types for the weight parameter resolver
//
// Function
// - List-1 chroma holds a gain and a bias per reference index, component 1 Cb and 2 Cr.
// - With list1_chroma_present low, list-1 chroma gains are 2^chroma_denom and biases zero.
// - A count field says how many custom pair entries are valid, and that many apply, up to the 4 in the table.
// - Each custom entry carries the list-0 reference index it applies to.
// - Each custom entry carries the list-1 reference index it applies to.
// - Each sent pair stores separate list-0 and list-1 luma gains used only for that pair.
// - Each sent pair stores one luma bias applied to the combined luma prediction.
// - Each sent pair stores list-0 and list-1 chroma gains for both Cb and Cr.
// - Each sent pair stores one chroma bias per component, Cb and Cr.
// - A pair with its chroma present flag low uses 2^chroma_denom Cb and Cr gains and zero Cb and Cr biases.
// - An unsent pair takes list-0 gains from list 0 and list-1 gains from list 1 per index.
// - An unsent pair's bias is the rounded average (b0 + b1 + 1) >> 1 of the list biases.
// - The luma and chroma denominator fields are base-two logs of the gain divisors.
// - With a list's luma present flag low, its luma gains are 2^luma_denom and biases zero.
package bwr_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NREF   = 4;
  localparam int NCUST  = 4;
  localparam int NCOMP  = 3;

  // ----------------------------------------------------------------
  // Components
  // ----------------------------------------------------------------
  localparam logic [1:0] COMP_LUMA = 2'h0;
  localparam logic [1:0] COMP_CB   = 2'h1;
  localparam logic [1:0] COMP_CR   = 2'h2;

  // ----------------------------------------------------------------
  // Register map (byte offsets within the 4 KiB window)
  // ----------------------------------------------------------------
  localparam logic [3:0]  PAGE_CTRL   = 4'h0;
  localparam logic [3:0]  PAGE_LIST   = 4'h1;
  localparam logic [3:0]  PAGE_CUST   = 4'h2;
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [1:0]  CUST_W_REFS = 2'h0;

  // Control word fields
  localparam int CTRL_LDEN_LSB  = 0;
  localparam int CTRL_CDEN_LSB  = 4;
  localparam int CTRL_L0L_BIT   = 8;
  localparam int CTRL_L0C_BIT   = 9;
  localparam int CTRL_L1L_BIT   = 10;
  localparam int CTRL_L1C_BIT   = 11;
  localparam int CTRL_CNT_LSB   = 16;
  // Custom entry word 0 fields
  localparam int REFS_R0_LSB    = 0;
  localparam int REFS_R1_LSB    = 4;
  localparam int REFS_CHP_BIT   = 8;
  // Gain/bias words
  localparam int WB_G0_LSB      = 0;
  localparam int WB_G1_LSB      = 8;
  localparam int WB_B_LSB       = 16;
  localparam int WL_B_LSB       = 8;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [1:0]  HTRANS_NONSEQ_BIT = 2'h2;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NCOMP-1:0][7:0] gain;
    logic [NCOMP-1:0][7:0] bias;
  } bwr_list_ent_s;

  typedef struct packed {
    logic [1:0]            ref0;
    logic [1:0]            ref1;
    logic                  chroma_present;
    logic [NCOMP-1:0][7:0] gain0;
    logic [NCOMP-1:0][7:0] gain1;
    logic [NCOMP-1:0][7:0] bias;
  } bwr_cust_s;

  typedef struct packed {
    logic [1:0] idx0;
    logic [1:0] idx1;
    logic [1:0] comp;
  } bwr_req_s;

  typedef struct packed {
    logic [8:0] gain0;
    logic [8:0] gain1;
    logic [7:0] bias;
    logic       hit;
  } bwr_res_s;

endpackage : bwr_pkg

// [bwr_resolver.sv]
// Weighted-prediction parameter store and resolver with an AHB-Lite slave
`timescale 1ns/100ps
module bwr_resolver (
  input  wire logic          clock,
  input  wire logic          rst_n,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic [31:0]        hrdata,
  output logic               hreadyout,
  output logic               hresp,
  input  wire logic          lookup_valid,
  input  wire bwr_pkg::bwr_req_s lookup_req,
  output logic               result_valid,
  output bwr_pkg::bwr_res_s  result
);
  import bwr_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Default gain 2^denom; denom 0..7 fits a 9-bit signed value
  function automatic logic [8:0] pow2_gain(input logic [2:0] denom);
    pow2_gain = 9'h001 << denom;
  endfunction : pow2_gain

  function automatic logic [8:0] sext(input logic [7:0] v);
    sext = {v[7], v};
  endfunction : sext

  function automatic logic [7:0] avg_bias(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = sext(a) + sext(b) + 9'h001;
    avg_bias = s[8:1];
  endfunction : avg_bias

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0]   ctrl_ff, nxt_ctrl;
  bwr_list_ent_s list_ff [2][NREF];
  bwr_list_ent_s nxt_list [2][NREF];
  bwr_cust_s     cust_ff [NCUST];
  bwr_cust_s     nxt_cust [NCUST];
  logic          dwr_ff, nxt_dwr;
  logic [11:0]   daddr_ff, nxt_daddr;
  logic [31:0]   hrdata_ff, nxt_hrdata;
  logic          hready_ff;
  logic          res_valid_ff, nxt_res_valid;
  bwr_res_s      res_ff, nxt_res;
  logic          last_hit_ff, nxt_last_hit;

  logic [2:0]    luma_den;
  logic [2:0]    chroma_den;
  logic [2:0]    cust_cnt;

  // Control fields; denominators are log2 of the divisors
  // denominators as log2
  assign luma_den   = ctrl_ff[CTRL_LDEN_LSB +: 3];
  assign chroma_den = ctrl_ff[CTRL_CDEN_LSB +: 3];
  assign cust_cnt   = ctrl_ff[CTRL_CNT_LSB +: 3];

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // Address phase: capture write, build read data at once (zero wait)
  always_comb begin
    logic [11:0] a;
    logic [3:0]  pg;
    logic [1:0]  ix;
    logic [1:0]  w;
    a          = haddr[11:0];
    pg         = a[11:8];
    ix         = a[5:4];
    w          = a[3:2];
    nxt_dwr    = 1'b0;
    nxt_daddr  = daddr_ff;
    nxt_hrdata = 32'h0000_0000;
    if (hsel && hready && htrans[1] && (hsize == 3'h2) && (haddr[31:12] == 20'h00000)) begin
      nxt_dwr   = hwrite;
      nxt_daddr = a;
      if (hwrite) begin
        nxt_hrdata = 32'h0000_0000;
      end else if (a == ADDR_CTRL) begin
        nxt_hrdata = ctrl_ff;
      end else if (a == ADDR_STATUS) begin
        nxt_hrdata = {29'h0000_0000, last_hit_ff, res_valid_ff, 1'b1};
      end else if (pg == PAGE_LIST && a[7] == 1'b0 && w != 2'h3) begin
        nxt_hrdata[7:0]            = list_ff[a[6]][ix].gain[w];
        nxt_hrdata[WL_B_LSB +: 8]  = list_ff[a[6]][ix].bias[w];
      end else if (pg == PAGE_CUST && a[7:6] == 2'h0) begin
        if (w == CUST_W_REFS) begin
          nxt_hrdata[REFS_R0_LSB +: 2] = cust_ff[ix].ref0;
          nxt_hrdata[REFS_R1_LSB +: 2] = cust_ff[ix].ref1;
          nxt_hrdata[REFS_CHP_BIT]     = cust_ff[ix].chroma_present;
        end else begin
          nxt_hrdata[WB_G0_LSB +: 8] = cust_ff[ix].gain0[w - 2'h1];
          nxt_hrdata[WB_G1_LSB +: 8] = cust_ff[ix].gain1[w - 2'h1];
          nxt_hrdata[WB_B_LSB +: 8]  = cust_ff[ix].bias[w - 2'h1];
        end
      end else begin
        nxt_hrdata = 32'h0000_0000;
      end
    end
  end

  // Data phase: write the captured address; unmapped writes vanish
  always_comb begin
    logic [3:0] pg;
    logic [1:0] ix;
    logic [1:0] w;
    pg       = daddr_ff[11:8];
    ix       = daddr_ff[5:4];
    w        = daddr_ff[3:2];
    nxt_ctrl = ctrl_ff;
    nxt_list = list_ff;
    nxt_cust = cust_ff;
    if (dwr_ff) begin
      if (daddr_ff == ADDR_CTRL) begin
        nxt_ctrl = hwdata;
      end else if (pg == PAGE_LIST && daddr_ff[7] == 1'b0 && w != 2'h3) begin
        // per-index gain and bias, Cb and Cr separately
        nxt_list[daddr_ff[6]][ix].gain[w] = hwdata[7:0];
        nxt_list[daddr_ff[6]][ix].bias[w] = hwdata[WL_B_LSB +: 8];
      end else if (pg == PAGE_CUST && daddr_ff[7:6] == 2'h0) begin
        if (w == CUST_W_REFS) begin
          nxt_cust[ix].ref0           = hwdata[REFS_R0_LSB +: 2];
          nxt_cust[ix].ref1           = hwdata[REFS_R1_LSB +: 2];
          nxt_cust[ix].chroma_present = hwdata[REFS_CHP_BIT];
        end else begin
          // separate per-list gains for the pair
          nxt_cust[ix].gain0[w - 2'h1] = hwdata[WB_G0_LSB +: 8];
          nxt_cust[ix].gain1[w - 2'h1] = hwdata[WB_G1_LSB +: 8];
          // one bias per component for the pair
          nxt_cust[ix].bias[w - 2'h1]  = hwdata[WB_B_LSB +: 8];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Resolver
  // ----------------------------------------------------------------
  // One registered answer per lookup of components 0..2; custom match beats inference
  always_comb begin
    logic       chroma;
    logic       p0;
    logic       p1;
    logic [8:0] g0;
    logic [8:0] g1;
    logic [7:0] b0;
    logic [7:0] b1;
    logic [8:0] dflt;
    logic       found;
    bwr_cust_s  ce;
    chroma        = (lookup_req.comp != COMP_LUMA);
    dflt          = chroma ? pow2_gain(chroma_den) : pow2_gain(luma_den);
    p0            = chroma ? ctrl_ff[CTRL_L0C_BIT] : ctrl_ff[CTRL_L0L_BIT];
    p1            = chroma ? ctrl_ff[CTRL_L1C_BIT] : ctrl_ff[CTRL_L1L_BIT];
    g0            = p0 ? sext(list_ff[0][lookup_req.idx0].gain[lookup_req.comp]) : dflt;
    b0            = p0 ? list_ff[0][lookup_req.idx0].bias[lookup_req.comp] : 8'h00;
    g1            = p1 ? sext(list_ff[1][lookup_req.idx1].gain[lookup_req.comp]) : dflt;
    b1            = p1 ? list_ff[1][lookup_req.idx1].bias[lookup_req.comp] : 8'h00;
    found         = 1'b0;
    ce            = cust_ff[0];
    // only the first cust_cnt entries are live; lowest index wins
    for (int e = NCUST - 1; e >= 0; e--) begin
      if (3'(e) < cust_cnt && cust_ff[e].ref0 == lookup_req.idx0
          && cust_ff[e].ref1 == lookup_req.idx1) begin
        found = 1'b1;
        ce    = cust_ff[e];
      end
    end
    nxt_res.hit = found;
    if (found && chroma && !ce.chroma_present) begin
      // absent pair chroma falls back to 2^denom, zero bias
      nxt_res.gain0 = dflt;
      nxt_res.gain1 = dflt;
      nxt_res.bias  = 8'h00;
    end else if (found) begin
      // sent pair wins; gains and bias per component
      nxt_res.gain0 = sext(ce.gain0[lookup_req.comp]);
      nxt_res.gain1 = sext(ce.gain1[lookup_req.comp]);
      nxt_res.bias  = ce.bias[lookup_req.comp];
    end else begin
      nxt_res.gain0 = g0;
      nxt_res.gain1 = g1;
      nxt_res.bias  = avg_bias(b0, b1);
    end
    nxt_res_valid = lookup_valid && (lookup_req.comp <= COMP_CR);
    nxt_last_hit  = nxt_res_valid ? found : last_hit_ff;
    if (!nxt_res_valid) begin
      nxt_res = res_ff;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Tables are left unreset: software loads them before any lookup
  always_ff @(posedge clock) begin
    list_ff <= nxt_list;
    cust_ff <= nxt_cust;
  end

  // Control and bus state with synchronous reset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_ff      <= CTRL_RESET;
      dwr_ff       <= 1'b0;
      daddr_ff     <= 12'h000;
      hrdata_ff    <= 32'h0000_0000;
      hready_ff    <= 1'b1;
      res_valid_ff <= 1'b0;
      res_ff       <= '0;
      last_hit_ff  <= 1'b0;
    end else begin
      ctrl_ff      <= nxt_ctrl;
      dwr_ff       <= nxt_dwr;
      daddr_ff     <= nxt_daddr;
      hrdata_ff    <= nxt_hrdata;
      hready_ff    <= 1'b1;
      res_valid_ff <= nxt_res_valid;
      res_ff       <= nxt_res;
      last_hit_ff  <= nxt_last_hit;
    end
  end

  // Outputs straight from flops except hresp, tied low so response is always OKAY
  assign hrdata       = hrdata_ff;
  assign hreadyout    = hready_ff;
  assign hresp        = 1'b0;
  assign result_valid = res_valid_ff;
  assign result       = res_ff;

endmodule : bwr_resolver

// [bwr_resolver_sva.sv]
// Port-level protocol checker for the weight parameter resolver
`timescale 1ns/100ps
module bwr_resolver_chk (
  input wire logic              clock,
  input wire logic              rst_n,
  input wire logic              hsel,
  input wire logic [31:0]       haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [31:0]       hrdata,
  input wire logic              hreadyout,
  input wire logic              hresp,
  input wire logic              lookup_valid,
  input wire bwr_pkg::bwr_req_s lookup_req,
  input wire logic              result_valid,
  input wire bwr_pkg::bwr_res_s result
);
  import bwr_pkg::*;
  // ----------------------------------------------------------------
  // Lookup answers and bus timing
  // ----------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  AST_LOOK_ANS: assert property (lookup_valid && lookup_req.comp != 2'h3 |=> result_valid)
    else $error("accepted lookup not answered");
  AST_LOOK_REFUSE: assert property (lookup_valid && lookup_req.comp == 2'h3
    |=> !result_valid && $stable(result)) else $error("component 3 was answered");
  AST_NO_SPARE: assert property (!lookup_valid |=> !result_valid)
    else $error("result without lookup");
  AST_RES_HOLD: assert property (!result_valid |-> $stable(result))
    else $error("result changed without valid");
  AST_BUS_READY: assert property (hreadyout) // zero wait slave
    else $error("hreadyout low");
  AST_BUS_OKAY: assert property (hresp == 1'b0) // response always okay
    else $error("hresp not okay");
  AST_RD_IDLE: assert property (!(hsel && htrans[1] && !hwrite) |=> hrdata == 32'h0) // idle bus
    else $error("read data without read");
  AST_STATUS: assert property (hsel && htrans[1] && !hwrite && haddr == 32'h4 // status
    |=> hrdata[0] == 1'b1) else $error("status bit 0 low");
endmodule : bwr_resolver_chk

// [bwr_parser_model.sv]
// Header parser stand-in that issues lookups to the resolver
`timescale 1ns/100ps
module bwr_parser_model (
  input  wire logic         clock,
  output logic              lookup_valid,
  output bwr_pkg::bwr_req_s lookup_req
);
  import bwr_pkg::*;
  // Quiet request lines at time zero
  initial begin
    lookup_valid = 1'b0;
    lookup_req   = '0;
  end
  // One lookup per edge, caller sits just after an edge
  task automatic issue(input bwr_req_s r);
    lookup_valid <= 1'b1;
    lookup_req   <= r;
    @(posedge clock);
  endtask : issue
  // Released request shows no stale value
  task automatic rest();
    lookup_valid <= 1'b0;
    lookup_req   <= ~lookup_req;
    @(posedge clock);
  endtask : rest
endmodule : bwr_parser_model

// [test_bwr_resolver.sv]
// Self-checking bench for the weight parameter resolver
`timescale 1ns/100ps
`define CHK(n, e, s) begin cmp_count++; if ((e) !== (s)) begin mismatches++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
module test_bwr_resolver;
  import bwr_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus state and reference tables
  // ----------------------------------------------------------------
  localparam logic [8:0] REFS [4] = '{9'h131, 9'h002, 9'h131, 9'h100};
  logic        clock = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, seed = 32'h7C27_08AC, hrdata;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2, ld, cd, cnt;
  logic        hreadyout, hresp, lookup_valid, result_valid, lh;
  logic [3:0]  fl;
  logic [31:0] lw [2][4][3], cw [4][3];
  bwr_req_s    lookup_req, req;
  bwr_res_s    result, nt;
  bwr_res_s    expq [$];
  int          mismatches = 0, cmp_count = 0;
  always #20 clock = ~clock;
  bwr_resolver uut (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .lookup_valid(lookup_valid),
    .lookup_req(lookup_req), .result_valid(result_valid), .result(result));
  bwr_parser_model far (.clock(clock), .lookup_valid(lookup_valid), .lookup_req(lookup_req));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Expected answer; lowest live custom entry wins, so scan downwards
  function automatic bwr_res_s model(input logic [1:0] i0, i1, c);
    bwr_res_s   r;
    logic [8:0] dg;
    logic [7:0] b0, b1;
    logic [9:0] s;
    logic       p0, p1;
    dg = 9'h1 << ((c == 2'h0) ? ld : cd);
    p0 = fl[(c == 2'h0) ? 0 : 1];
    p1 = fl[(c == 2'h0) ? 2 : 3];
    b0 = p0 ? lw[0][i0][c][15:8] : 8'h0;
    b1 = p1 ? lw[1][i1][c][15:8] : 8'h0;
    s = {{2{b0[7]}}, b0} + {{2{b1[7]}}, b1} + 10'h1;
    r.gain0 = p0 ? {lw[0][i0][c][7], lw[0][i0][c][7:0]} : dg;
    r.gain1 = p1 ? {lw[1][i1][c][7], lw[1][i1][c][7:0]} : dg;
    r.bias = s[8:1];
    r.hit = 1'b0;
    for (int e = 3; e >= 0; e--) begin
      if (e < cnt && REFS[e][1:0] == i0 && REFS[e][5:4] == i1) begin
        r.hit = 1'b1;
        p0 = (c == 2'h0) || REFS[e][8];
        r.gain0 = p0 ? {cw[e][c][7], cw[e][c][7:0]} : dg;
        r.gain1 = p0 ? {cw[e][c][15], cw[e][c][15:8]} : dg;
        r.bias = p0 ? cw[e][c][23:16] : 8'h0;
      end
    end
    return r;
  endfunction : model
  // ----------------------------------------------------------------
  // Bus master and closing
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  // Bounded wait for hready at an edge
  task automatic rdy();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) begin
      mismatches++;
      stop_test();
    end
  endtask : rdy
  task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    q = hrdata;
    hsel <= 1'b0;
    haddr <= ~a;
    // One idle edge so the next call never re-drives hsel in this step
    @(posedge clock);
  endtask : bus
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [31:0] a, e, input string n);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK(n, e, q)
  endtask : rd
  // Oldest note against each answer
  always @(posedge clock) begin
    if (result_valid === 1'b1) begin
      nt = (expq.size() > 0) ? expq.pop_front() : ~result;
      `CHK("result", nt, result)
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    rd(32'h0, 32'h0, "ctrl reset");
    rd(32'h4, 32'h1, "status reset");
    wr(32'h1000, seed);
    rd(32'h1000, 32'h0, "unmapped");
    for (int k = 0; k < 24; k++) begin
      seed = lfsr(seed);
      lw[k / 12][(k / 3) % 4][k % 3] = seed;
      wr(32'(256 + (k / 12) * 64 + ((k / 3) % 4) * 16 + (k % 3) * 4), seed);
    end
    for (int k = 0; k < 16; k++) begin
      seed = lfsr(seed);
      if (k % 4 != 0) cw[k / 4][k % 4 - 1] = seed;
      wr(32'(512 + k * 4), (k % 4 == 0) ? {23'h0, REFS[k / 4]} : seed);
    end
    // counts 0, 2 and past the table
    for (int t = 0; t < 48; t++) begin
      seed = lfsr(seed);
      fl = t[3:0];
      cnt = (t < 16) ? 3'h0 : (t < 32) ? 3'h2 : 3'h5;
      {cd, ld} = (t == 0) ? 6'h07 : {seed[6:4], seed[2:0]};
      wr(32'h0, {13'h0, cnt, 4'h0, fl, 1'b0, cd, 1'b0, ld});
      rd(32'h0, {13'h0, cnt, 4'h0, fl, 1'b0, cd, 1'b0, ld}, "ctrl");
      for (int k = 0; k < 64; k++) begin
        req = bwr_req_s'(k[5:0]);
        if (req.comp != 2'h3) expq.push_back(model(req.idx0, req.idx1, req.comp));
        far.issue(req);
      end
      // pair 1/3 hits only while entry 0 is live
      req = bwr_req_s'(6'h1C);
      expq.push_back(model(req.idx0, req.idx1, req.comp));
      lh = expq[expq.size() - 1].hit;
      far.issue(req);
      far.rest();
      far.rest();
      rd(32'h4, {29'h0, lh, 2'h1}, "status");
      $display("test %0d done", t);
    end
    `CHK("left notes", 0, expq.size())
    stop_test();
  end
endmodule : test_bwr_resolver
bind bwr_resolver bwr_resolver_chk chk (.clock(clock), .rst_n(rst_n), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .lookup_valid(lookup_valid), .lookup_req(lookup_req),
  .result_valid(result_valid), .result(result));
